/* File: verilog/txs_defines.svh */
// Constants for the transmit slice serializer, tri-state and delay line
// Summary of operation
// RQ1 - Every slice has its own block tri-state input
// RQ2 - Tri-state serializer turns 4-bit bus into stream
// RQ3 - Per-bit input high drives, low floats bit
// RQ4 - Serial data leaves synchronous to fast bit clock
// RQ5 - Tri-state output: pass-through or serialized per-bit stream
// RQ6 - Transmit reset high, asserts at once, releases synchronously
// RQ7 - Transmit reset forces serial output to initial value
// RQ8 - Delay controls sampled on delay control clock
// RQ9 - Driver keeps delay clock running in variable modes
// RQ10 - Delay clock-enable gates every tap update; the code lets a load pulse set the tap without it
// RQ11 - Delay reset restores default tap, releases on clock
// RQ12 - Data width 8 or 4; upper nibble tied low
// RQ13 - Enabled tap steps one per clock, direction-driven
// RQ14 - Tap counter wraps between 511 and 0
// RQ15 - Load pulse sets tap from count input
`ifndef TXS_DEFINES_SVH
`define TXS_DEFINES_SVH
`define TXS_DATA_WIDTH_MAX 8
`define TXS_DATA_WIDTH_MIN 4
`define TXS_HIZ_BUS_WIDTH  4
`define TXS_TAP_WIDTH      9
`define TXS_TAP_MAX        9'h1FF
`define TXS_TAP_DEFAULT    9'h000
`define TXS_INIT_VALUE     1'b0
`endif

/* File: verilog/txs_pkg.sv */
// Types shared by the transmit slice design
package txs_pkg;
  // Delay line operating mode
  typedef enum logic [1:0] {
    TXS_DLY_FIXED    = 2'b00,
    TXS_DLY_VARIABLE = 2'b01,
    TXS_DLY_VAR_LOAD = 2'b10
  } txs_dly_mode_t;
  // Source of the pad tri-state control
  typedef enum logic [0:0] {
    TXS_HIZ_BLOCK   = 1'b0,
    TXS_HIZ_PER_BIT = 1'b1
  } txs_hiz_src_t;
endpackage : txs_pkg

/* File: verilog/txs_tristate_serializer.sv */
// Serializer turning the nibble-wide tri-state bus into a per-bit stream
`timescale 1ns/1ps
`default_nettype none
`include "txs_defines.svh"
module txs_tristate_serializer
  import txs_pkg::*;
#(
  parameter int SPAN = 2
) (
  // Clock and reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_reset,
  // Frame start and tri-state bus
  input  wire logic                          i_load,
  input  wire logic [`TXS_HIZ_BUS_WIDTH-1:0] i_hiz_bus,
  // Serial per-bit drive stream, high means driven
  output logic                               o_stream
);
  localparam int SW = (SPAN > 1) ? $clog2(SPAN) : 1;

  // Refuse a span that cannot cover any data bit
  if (SPAN < 1) begin : g_bad_span
    $error("SPAN must be at least 1");
  end

  logic [`TXS_HIZ_BUS_WIDTH-1:0] shreg_q;
  logic [SW-1:0]                 sub_q;
  logic                          stream_q;

  // Each bus bit covers SPAN serial data bits
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      shreg_q  <= '0;
      sub_q    <= '0;
      stream_q <= 1'b0;
    end else if (i_load) begin
      shreg_q  <= i_hiz_bus; // see RQ2
      sub_q    <= '0;
      stream_q <= i_hiz_bus[0];
    end else if (sub_q == SW'(SPAN - 1)) begin
      shreg_q  <= shreg_q >> 1;
      sub_q    <= '0;
      stream_q <= shreg_q[1];
    end else begin
      sub_q    <= sub_q + SW'(1);
    end
  end

  assign o_stream = stream_q;
endmodule : txs_tristate_serializer
`default_nettype wire

/* File: verilog/txs_transmit_slice.sv */
// Transmit slice: data serializer, tri-state select and output delay line
`timescale 1ns/1ps
`default_nettype none
`include "txs_defines.svh"
module txs_transmit_slice
  import txs_pkg::*;
#(
  parameter int            DATA_WIDTH  = `TXS_DATA_WIDTH_MAX,
  parameter logic          INIT_VALUE  = `TXS_INIT_VALUE,
  parameter txs_dly_mode_t DELAY_MODE  = TXS_DLY_VAR_LOAD,
  parameter logic [8:0]    DELAY_VALUE = `TXS_TAP_DEFAULT,
  parameter logic          INVERT_DCLK = 1'b0
) (
  // Fast bit clock and system reset
  input  wire logic                          i_mclk,
  input  wire logic                          i_reset,
  // Transmit reset, active high
  input  wire logic                          i_tx_reset,
  // Parallel data from fabric
  input  wire logic [`TXS_DATA_WIDTH_MAX-1:0] i_data,
  // Tri-state controls
  input  wire logic                          i_block_hiz,
  input  wire logic [`TXS_HIZ_BUS_WIDTH-1:0] i_hiz_bus,
  input  wire txs_hiz_src_t                  i_hiz_source_select,
  // Delay line controls
  input  wire logic                          i_dly_clk,
  input  wire logic                          i_delay_line_reset,
  input  wire logic                          i_dly_ce,
  input  wire logic                          i_dly_inc,
  input  wire logic                          i_dly_load,
  input  wire logic [`TXS_TAP_WIDTH-1:0]     i_delay_tap_load_value,
  // Pad side
  output logic                               o_serial,
  output logic                               o_tristate,
  output logic                               o_frame_start,
  // Delay tap in use
  output logic [`TXS_TAP_WIDTH-1:0]          o_tap_value
);
  localparam int CW = 3;

  // Refuse widths the serializer cannot frame
  if (DATA_WIDTH != `TXS_DATA_WIDTH_MAX && DATA_WIDTH != `TXS_DATA_WIDTH_MIN) begin : g_bad_width
    $error("DATA_WIDTH must be 8 or 4");
  end

  // Next tap value with wrap in both directions
  function automatic logic [`TXS_TAP_WIDTH-1:0] tap_step(
    input logic [`TXS_TAP_WIDTH-1:0] tap,
    input logic                      up
  );
    if (up) begin
      tap_step = (tap == `TXS_TAP_MAX) ? '0 : tap + 9'h001; // see RQ14
    end else begin
      tap_step = (tap == '0) ? `TXS_TAP_MAX : tap - 9'h001; // see RQ14
    end
  endfunction : tap_step

  // ---------------- Serializer ----------------
  logic                           tx_hold_q;
  logic                           tx_active;
  logic [CW-1:0]                  bit_cnt_q;
  logic [`TXS_DATA_WIDTH_MAX-1:0] shreg_q;
  logic                           serial_q;
  logic                           load;
  logic [`TXS_DATA_WIDTH_MAX-1:0] data_used;

  // Reset acts at once, release waits one bit clock
  assign tx_active = i_tx_reset | tx_hold_q; // see RQ6

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      tx_hold_q <= 1'b1;
    end else begin
      tx_hold_q <= i_tx_reset; // see RQ6
    end
  end

  assign load = ~tx_active && (bit_cnt_q == '0);
  // Upper nibble ignored in 4-bit mode
  assign data_used = (DATA_WIDTH == `TXS_DATA_WIDTH_MIN) ?
                     {4'h0, i_data[3:0]} : i_data; // see RQ12

  // Frame bit counter
  always_ff @(posedge i_mclk) begin
    if (i_reset || tx_active) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q == CW'(DATA_WIDTH - 1)) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= bit_cnt_q + CW'(1);
    end
  end

  // Shift register, least significant bit first
  always_ff @(posedge i_mclk) begin
    if (i_reset || tx_active) begin
      shreg_q  <= '0;
      serial_q <= INIT_VALUE;
    end else if (load) begin
      shreg_q  <= data_used;
      serial_q <= data_used[0]; // see RQ4
    end else begin
      shreg_q  <= shreg_q >> 1;
      serial_q <= shreg_q[1]; // see RQ4
    end
  end

  // Initial value shown while reset is asserted
  assign o_serial      = tx_active ? INIT_VALUE : serial_q; // see RQ7
  assign o_frame_start = load;

  // ---------------- Tri-state ----------------
  logic per_bit_hiz_input;

  txs_tristate_serializer #(
    .SPAN (DATA_WIDTH / `TXS_HIZ_BUS_WIDTH)
  ) u_tristate_serializer (
    .i_mclk    (i_mclk),
    .i_reset   (i_reset | tx_active),
    .i_load    (load),
    .i_hiz_bus (i_hiz_bus), // see RQ2
    .o_stream  (per_bit_hiz_input)
  );

  // High on the pad means high impedance
  always_comb begin
    if (tx_active) begin
      o_tristate = 1'b1;
    end else if (i_hiz_source_select == TXS_HIZ_PER_BIT) begin
      o_tristate = ~per_bit_hiz_input; // see RQ3 see RQ5
    end else begin
      o_tristate = i_block_hiz; // see RQ1 see RQ5
    end
  end

  // ---------------- Delay line ----------------
  logic                      dclk_prev_q;
  logic                      dclk_lvl;
  logic                      dly_tick;
  logic                      dly_rst_q;
  logic [`TXS_TAP_WIDTH-1:0] tap_q;

  // Delay clock edge detect, optional local inversion
  assign dclk_lvl = i_dly_clk ^ INVERT_DCLK;
  assign dly_tick = dclk_lvl & ~dclk_prev_q; // see RQ8 see RQ9

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      dclk_prev_q <= INVERT_DCLK; // Idle pin level, no false edge after reset
    end else begin
      dclk_prev_q <= dclk_lvl;
    end
  end

  // Delay reset held until a control clock edge sees it low
  always_ff @(posedge i_mclk) begin
    if (i_reset || i_delay_line_reset) begin
      dly_rst_q <= 1'b1;
    end else if (dly_tick) begin
      dly_rst_q <= 1'b0; // see RQ11
    end
  end

  // Tap register, stepped or loaded on control clock edges only; resets restore the default tap at once
  always_ff @(posedge i_mclk) begin
    if (i_reset || i_delay_line_reset || dly_rst_q) begin
      tap_q <= DELAY_VALUE; // see RQ11
    end else if (dly_tick) begin
      if (DELAY_MODE == TXS_DLY_VAR_LOAD && i_dly_load) begin
        tap_q <= i_delay_tap_load_value; // see RQ15
      end else if (DELAY_MODE != TXS_DLY_FIXED && i_dly_ce) begin
        tap_q <= tap_step(tap_q, i_dly_inc); // see RQ10 see RQ13
      end
    end
  end

  assign o_tap_value = i_delay_line_reset ? DELAY_VALUE : tap_q; // see RQ11
endmodule : txs_transmit_slice
`default_nettype wire

/* File: tb/txs_pad_model.sv */
// Pad buffer model at the far side of the transmit slice
`timescale 1ns/1ps
`default_nettype none
module txs_pad_model (
  // Clock
  input  wire logic i_mclk,
  // Streams from the slice
  input  wire logic i_serial,
  input  wire logic i_tristate,
  // Pad level
  output logic      o_pad
);
  logic last_q;
  // Last driven level, so a floating pad never looks driven
  always_ff @(posedge i_mclk) if (!i_tristate) last_q <= i_serial;
  assign o_pad = i_tristate ? ~last_q : i_serial;
endmodule : txs_pad_model
`default_nettype wire

/* File: tb/txs_slice_properties.sv */
// Port checker for the transmit slice
`timescale 1ns/1ps
`default_nettype none
module txs_slice_checker
  import txs_pkg::*;
#(
  parameter logic       INIT_VALUE  = 1'b0,
  parameter logic [8:0] DELAY_VALUE = 9'h000
) (
  // Clock and resets
  input wire logic         i_mclk,
  input wire logic         i_reset,
  input wire logic         i_tx_reset,
  input wire logic         i_delay_line_reset,
  // Data and tri-state inputs
  input wire logic [7:0]   i_data,
  input wire logic         i_block_hiz,
  input wire logic [3:0]   i_hiz_bus,
  input wire txs_hiz_src_t i_hiz_source_select,
  // Delay controls
  input wire logic         i_dly_clk,
  input wire logic         i_dly_ce,
  input wire logic         i_dly_inc,
  input wire logic         i_dly_load,
  input wire logic [8:0]   i_delay_tap_load_value,
  // Outputs
  input wire logic         o_serial,
  input wire logic         o_tristate,
  input wire logic         o_frame_start,
  input wire logic [8:0]   o_tap_value
);
  logic dclk_q;
  logic arm_q;
  logic rise;
  logic tx_held_q;
  // Delay clock edge, and arming once an edge is seen out of reset
  assign rise = i_dly_clk & ~dclk_q;
  always_ff @(posedge i_mclk) dclk_q <= i_dly_clk;
  always_ff @(posedge i_mclk)
    if (i_reset || i_delay_line_reset) arm_q <= 1'b0;
    else if (rise) arm_q <= 1'b1;
  // Transmit reset release takes effect one bit clock late
  always_ff @(posedge i_mclk)
    if (i_reset) tx_held_q <= 1'b1;
    else tx_held_q <= i_tx_reset;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_tx_init_value: assert property (i_tx_reset |-> o_serial == INIT_VALUE)
    else $error("serial not at init during transmit reset");
  a_frame_spacing: assert property (disable iff (i_reset || i_tx_reset)
    o_frame_start |=> !o_frame_start [*7] ##1 o_frame_start) else $error("frame spacing wrong");
  a_serial_lsb_first: assert property (disable iff (i_reset || i_tx_reset)
    o_frame_start |=> o_serial == $past(i_data[0]) ##1 o_serial == $past(i_data[1], 2))
    else $error("serial bit order wrong");
  a_block_hiz_pass: assert property (
    !i_tx_reset && !tx_held_q && i_hiz_source_select == TXS_HIZ_BLOCK
    |-> o_tristate == i_block_hiz) else $error("block tri-state not passed");
  a_tx_hiz_forced: assert property (i_tx_reset || tx_held_q |-> o_tristate)
    else $error("tri-state not forced during transmit reset");
  a_per_bit_hiz: assert property (disable iff (i_reset || i_tx_reset)
    o_frame_start && i_hiz_source_select == TXS_HIZ_PER_BIT |=> o_tristate == !$past(i_hiz_bus[0]))
    else $error("per-bit tri-state wrong");
  a_tap_hold: assert property (
    !(rise && (i_dly_ce || i_dly_load)) && !i_delay_line_reset
    |=> $stable(o_tap_value) || i_delay_line_reset) else $error("tap changed without enable");
  a_tap_step: assert property (
    rise && arm_q && i_dly_ce && !i_dly_load && !i_delay_line_reset
    |=> o_tap_value == $past(o_tap_value) + ($past(i_dly_inc) ? 9'h001 : 9'h1FF))
    else $error("tap step wrong");
  a_tap_load: assert property (rise && arm_q && i_dly_load && !i_delay_line_reset
    |=> o_tap_value == $past(i_delay_tap_load_value)) else $error("tap load wrong");
  a_dly_reset_tap: assert property (i_delay_line_reset |-> o_tap_value == DELAY_VALUE)
    else $error("tap not at default in delay reset");
endmodule : txs_slice_checker
bind txs_transmit_slice txs_slice_checker #(.INIT_VALUE(INIT_VALUE), .DELAY_VALUE(DELAY_VALUE))
  chk_u (.i_mclk, .i_reset, .i_tx_reset, .i_delay_line_reset, .i_data, .i_block_hiz, .i_hiz_bus,
  .i_hiz_source_select, .i_dly_clk, .i_dly_ce, .i_dly_inc, .i_dly_load, .i_delay_tap_load_value,
  .o_serial, .o_tristate, .o_frame_start, .o_tap_value);
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the transmit slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  i_mclk = 0, i_reset = 1, i_tx_reset = 0, i_block_hiz = 0, pad;
  logic                  i_dly_clk = 0, i_delay_line_reset = 1, i_dly_ce = 0, i_dly_inc = 0;
  logic                  i_dly_load = 0, o_serial, o_tristate, o_frame_start;
  logic [7:0]            i_data = 8'h00;
  logic [3:0]            i_hiz_bus = 4'h0;
  logic [8:0]            i_delay_tap_load_value = 9'h000, o_tap_value, exp_tap = 9'h000;
  logic [2:0]            e, sq[$];
  logic [8:0]            tq[$];
  txs_pkg::txs_hiz_src_t i_hiz_source_select = txs_pkg::TXS_HIZ_BLOCK;
  int                    bad_count = 0, tests_run = 0, seed = 73;
  bit                    armed = 0;
  // Clock and instances
  initial forever #2.5 i_mclk = ~i_mclk;
  txs_transmit_slice dut_u (.i_mclk, .i_reset, .i_tx_reset, .i_data, .i_block_hiz, .i_hiz_bus,
    .i_hiz_source_select, .i_dly_clk, .i_delay_line_reset, .i_dly_ce, .i_dly_inc, .i_dly_load,
    .i_delay_tap_load_value, .o_serial, .o_tristate, .o_frame_start, .o_tap_value);
  txs_pad_model pad_u (.i_mclk, .i_serial(o_serial), .i_tristate(o_tristate), .o_pad(pad));
  task automatic check(string n, logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // One delay clock rise with the given controls; notes the tap expected
  task automatic dly(bit ce, bit inc, bit ld, logic [8:0] v);
    @(posedge i_mclk);
    i_dly_ce <= ce;
    i_dly_inc <= inc;
    i_dly_load <= ld;
    i_delay_tap_load_value <= v;
    i_dly_clk <= 1'b1;
    @(posedge i_mclk);
    if (armed) exp_tap = ld ? v : ce ? exp_tap + (inc ? 9'h001 : 9'h1FF) : exp_tap;
    armed = 1;
    tq.push_back(exp_tap);
    i_dly_clk <= 1'b0;
    i_dly_ce <= 1'b0;
    i_dly_load <= 1'b0;
  endtask : dly
  // Random traffic; each frame start notes its serial and tri-state bits
  always @(posedge i_mclk) begin
    if (o_frame_start === 1'b1 && !i_tx_reset && !i_reset)
      for (int k = 0; k < 8; k++)
        sq.push_back({i_hiz_source_select == txs_pkg::TXS_HIZ_PER_BIT, !i_hiz_bus[k/2], i_data[k]});
    i_data <= 8'($random(seed));
    i_hiz_bus <= 4'($random(seed));
    i_block_hiz <= 1'($random(seed));
  end
  // Oldest notes compared half a cycle after each edge
  always @(negedge i_mclk) begin
    if (sq.size() > 0 && !i_tx_reset) begin
      e = sq.pop_front();
      check("serial", o_serial, e[0]);
      if (e[2]) check("tristate", o_tristate, e[1]);
      else if (i_hiz_source_select == txs_pkg::TXS_HIZ_BLOCK)
        check("block tristate", o_tristate, i_block_hiz);
      if (e[2] && !e[1]) check("pad", pad, e[0]);
    end
    if (tq.size() > 0) check("tap", o_tap_value, tq.pop_front());
  end
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    i_delay_line_reset <= 1'b0;
    repeat (40) @(posedge i_mclk);
    @(posedge i_mclk iff o_frame_start);
    @(posedge i_mclk);
    i_hiz_source_select <= txs_pkg::TXS_HIZ_PER_BIT;
    repeat (40) @(posedge i_mclk);
    i_tx_reset <= 1'b1;
    @(posedge i_mclk);
    sq.delete();
    repeat (4) @(posedge i_mclk);
    i_tx_reset <= 1'b0;
    repeat (30) @(posedge i_mclk);
    dly(0, 0, 0, 9'h000);
    dly(0, 0, 1, 9'h1FE);
    repeat (3) dly(1, 1, 0, 9'h000);
    repeat (3) dly(1, 0, 0, 9'h000);
    dly(0, 1, 0, 9'h000);
    dly(0, 0, 1, 9'($random(seed)));
    @(posedge i_mclk);
    i_delay_line_reset <= 1'b1;
    armed = 0;
    exp_tap = 9'h000;
    @(posedge i_mclk);
    tq.push_back(exp_tap);
    i_delay_line_reset <= 1'b0;
    repeat (2) dly(1, 1, 0, 9'h000);
    repeat (4) @(posedge i_mclk);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
